// [logic/twbc_defines.vh]
// Register offsets, field positions, reset values and bus timing of the
// two-wire bus controller. Definitions only; included by bare name.
`ifndef TWBC_DEFINES_VH
`define TWBC_DEFINES_VH

// Register byte offsets
`define TWBC_OFF_CTRL      8'h00
`define TWBC_OFF_CTRL2     8'h04
`define TWBC_OFF_TXDATA    8'h08
`define TWBC_OFF_RXDATA    8'h0C
`define TWBC_OFF_ISR       8'h10
`define TWBC_OFF_MASK      8'h14
`define TWBC_OFF_OWNADR    8'h18

// Control register fields
`define TWBC_CTRL_PE       0
`define TWBC_CTRL_STR_DIS  1
`define TWBC_CTRL_WAKE_EN  2
`define TWBC_CTRL_RESET    3'h0

// Control register two fields
`define TWBC_CR2_READ      10
`define TWBC_CR2_ADDR10    11
`define TWBC_CR2_START     12
`define TWBC_CR2_RESET     13'h0000

// Interrupt status register fields
`define TWBC_ISR_BUSY      0
`define TWBC_ISR_NACK      1
`define TWBC_ISR_STOP      2
`define TWBC_ISR_BUS_ERROR_FLAG      3
`define TWBC_ISR_ADDR      4
`define TWBC_ISR_DONE      5
`define TWBC_EVT_RESET     6'h00
`define TWBC_OWN_RESET     7'h00
`define TWBC_BYTE_RESET    8'h00

// Header of a 10-bit address
`define TWBC_HDR10         5'h1E

// Bus timing
`define TWBC_SCL_HALF_NS   5000
`define TWBC_CLK_MHZ       20
`define TWBC_SCL_HALF_CYC  ((`TWBC_SCL_HALF_NS * `TWBC_CLK_MHZ) / 1000)

`endif

// [logic/twbc_sync.v]
// Two-flop synchroniser for bus pins entering the pclk domain.
// Assumes its inputs are asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none

module twbc_sync #(
    parameter WIDTH = 2                      // Bits carried
) (
    input  wire             clk,             // Sampling clock
    input  wire             rst_n,           // Async reset, active low
    input  wire [WIDTH-1:0] d,               // Asynchronous input
    output wire [WIDTH-1:0] q                // Synchronised output
);

    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;

    // Idle bus level is high
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= {WIDTH{1'b1}};
            sync_reg <= {WIDTH{1'b1}};
        end else begin
            meta_reg <= d;
            sync_reg <= meta_reg;
        end
    end

    assign q = sync_reg;

endmodule // twbc_sync

`default_nettype wire

// [logic/twbc_bus_mon.v]
// Bus condition monitor: START, STOP, SCL edges and bus busy.
// Assumes synchronised SCL and SDA in the pclk domain.
`timescale 1ns/1ns
`default_nettype none

module twbc_bus_mon (
    input  wire pclk,                        // Kernel clock
    input  wire presetn,                     // Async reset, active low
    input  wire enable,                      // Peripheral enabled
    input  wire scl_s,                       // Synchronised SCL
    input  wire sda_s,                       // Synchronised SDA
    output wire start_det,                   // START seen, one pulse
    output wire stop_det,                    // STOP seen, one pulse
    output wire scl_rise,                    // SCL rose, one pulse
    output wire scl_fall,                    // SCL fell, one pulse
    output wire bus_busy                     // Between START and STOP
);

    reg scl_d_reg;
    reg sda_d_reg;
    reg start_reg;
    reg stop_reg;
    reg rise_reg;
    reg fall_reg;
    reg busy_reg;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            start_reg <= 1'b0;
            stop_reg  <= 1'b0;
            rise_reg  <= 1'b0;
            fall_reg  <= 1'b0;
            busy_reg  <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            start_reg <= enable & scl_s & scl_d_reg & sda_d_reg & ~sda_s;
            stop_reg  <= enable & scl_s & scl_d_reg & ~sda_d_reg & sda_s;
            rise_reg  <= enable & scl_s & ~scl_d_reg;
            fall_reg  <= enable & ~scl_s & scl_d_reg;
            if (!enable) begin
                busy_reg <= 1'b0;
            end else if (start_reg) begin
                busy_reg <= 1'b1;
            end else if (stop_reg) begin
                busy_reg <= 1'b0;
            end
        end
    end

    assign start_det = start_reg;
    assign stop_det  = stop_reg;
    assign scl_rise  = rise_reg;
    assign scl_fall  = fall_reg;
    assign bus_busy  = busy_reg;

endmodule // twbc_bus_mon

`default_nettype wire

// [logic/twbc_top.v]
// Two-wire bus controller: APB registers, master engine, slave matcher.
// Assumes open-drain pads outside; pins are asynchronous to pclk.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "twbc_defines.vh"

module twbc_top #(
    parameter HALF_CYC = `TWBC_SCL_HALF_CYC  // SCL half period in cycles
) (
    input  wire        pclk,                 // Kernel and APB clock
    input  wire        presetn,              // Async reset, active low
    input  wire [7:0]  paddr,                // APB address
    input  wire        psel,                 // APB select
    input  wire        penable,              // APB enable
    input  wire        pwrite,               // APB direction
    input  wire [31:0] pwdata,               // APB write data
    output wire [31:0] prdata,               // APB read data
    output wire        pready,               // APB ready
    output wire        pslverr,              // APB error
    input  wire        scl_in,               // SCL pin level
    output wire        scl_out,              // SCL drive value
    output wire        scl_oe,               // SCL pulled low
    input  wire        sda_in,               // SDA pin level
    output wire        sda_out,              // SDA drive value
    output wire        sda_oe,               // SDA pulled low
    input  wire        stop_mode,            // MCU in Stop mode
    output wire        wakeup_req,           // Wakeup request
    output wire        irq                   // Interrupt, level
);

    localparam [2:0] M_IDLE = 3'h0;
    localparam [2:0] M_STA  = 3'h1;
    localparam [2:0] M_BLO  = 3'h2;
    localparam [2:0] M_BHI  = 3'h3;
    localparam [2:0] M_SPO1 = 3'h4;
    localparam [2:0] M_SPO2 = 3'h5;
    localparam [2:0] M_SPO3 = 3'h6;

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_ADDR = 2'h1;
    localparam [1:0] S_ACK  = 2'h2;
    localparam [1:0] S_HOLD = 2'h3;

    localparam [1:0] P_HDR  = 2'h0;
    localparam [1:0] P_LOW  = 2'h1;
    localparam [1:0] P_DATA = 2'h2;

    localparam [15:0] HALF  = HALF_CYC[15:0];

    reg  [2:0]  ctrl_reg;
    reg  [12:0] cr2_reg;
    reg  [7:0]  txd_reg;
    reg  [7:0]  rxd_reg;
    reg  [5:0]  evt_reg;
    reg  [5:0]  mask_reg;
    reg  [6:0]  own_reg;
    reg  [31:0] prdata_reg;
    reg         irq_reg;
    reg         wake_reg;

    reg  [2:0]  m_state_reg;
    reg  [15:0] tmr_reg;
    reg  [3:0]  bit_reg;
    reg  [7:0]  shf_reg;
    reg  [1:0]  phase_reg;
    reg         m_scl_oe_reg;
    reg         m_sda_oe_reg;

    reg  [1:0]  s_state_reg;
    reg  [3:0]  s_cnt_reg;
    reg  [7:0]  s_shf_reg;
    reg         s_scl_oe_reg;
    reg         s_sda_oe_reg;

    wire        scl_s;
    wire        sda_s;
    wire        start_det;
    wire        stop_det;
    wire        scl_rise;
    wire        scl_fall;
    wire        bus_busy;

    wire pe       = ctrl_reg[`TWBC_CTRL_PE];
    wire str_dis  = ctrl_reg[`TWBC_CTRL_STR_DIS];
    wire wake_en  = ctrl_reg[`TWBC_CTRL_WAKE_EN];
    wire rd_dir   = cr2_reg[`TWBC_CR2_READ];
    wire addr10   = cr2_reg[`TWBC_CR2_ADDR10];
    wire start_rq = cr2_reg[`TWBC_CR2_START];

    // Pins pass two flops before any logic reads them
    twbc_sync #(
        .WIDTH (2)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .d     ({scl_in, sda_in}),
        .q     ({scl_s, sda_s})
    );

    twbc_bus_mon u_mon (
        .pclk      (pclk),
        .presetn   (presetn),
        .enable    (pe),
        .scl_s     (scl_s),
        .sda_s     (sda_s),
        .start_det (start_det),
        .stop_det  (stop_det),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .bus_busy  (bus_busy)
    );

    function mapped;
        input [7:0] a;
        begin
            mapped = (a == `TWBC_OFF_CTRL)   || (a == `TWBC_OFF_CTRL2) ||
                     (a == `TWBC_OFF_TXDATA) || (a == `TWBC_OFF_RXDATA) ||
                     (a == `TWBC_OFF_ISR)    || (a == `TWBC_OFF_MASK) ||
                     (a == `TWBC_OFF_OWNADR);
        end
    endfunction

    // Master bit end: SCL seen high for a full half period
    wire m_bit_end = (m_state_reg == M_BHI) && scl_s && (tmr_reg == 16'h0000);
    wire m_ack_end = m_bit_end && (bit_reg == 4'h8);
    wire ev_nack   = m_ack_end && (phase_reg != P_DATA) && sda_s;
    wire clr_start = ev_nack || (m_ack_end && (phase_reg != P_DATA) &&
                     !(phase_reg == P_HDR && addr10));
    wire ev_done   = m_ack_end && (phase_reg == P_DATA);
    wire in_bits   = (m_state_reg == M_BLO) || (m_state_reg == M_BHI);
    wire ev_bus_error_flag   = (start_det || stop_det) && in_bits;
    wire ev_addr   = (s_state_reg == S_ACK) && scl_fall;
    wire [5:0] ev_vec = {ev_done, ev_addr, ev_bus_error_flag, stop_det, ev_nack, 1'b0};

    wire apb_wr   = psel && penable && pwrite && mapped(paddr);
    wire apb_rdst = psel && !penable && !pwrite;

    // APB register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `TWBC_CTRL_RESET;
            txd_reg  <= `TWBC_BYTE_RESET;
            mask_reg <= `TWBC_EVT_RESET;
            own_reg  <= `TWBC_OWN_RESET;
        end else if (apb_wr) begin
            case (paddr)
                `TWBC_OFF_CTRL:   ctrl_reg <= pwdata[2:0];
                `TWBC_OFF_TXDATA: txd_reg  <= pwdata[7:0];
                `TWBC_OFF_MASK:   mask_reg <= {pwdata[5:1], 1'b0};
                `TWBC_OFF_OWNADR: own_reg  <= pwdata[6:0];
                default:          own_reg  <= own_reg;
            endcase
        end
    end

    // Start request: a software write wins over the hardware clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cr2_reg <= `TWBC_CR2_RESET;
        end else if (apb_wr && paddr == `TWBC_OFF_CTRL2) begin
            cr2_reg <= pwdata[12:0];
        end else if (clr_start || !pe) begin
            cr2_reg[`TWBC_CR2_START] <= 1'b0;
        end
    end

    // Sticky events, write one to clear; a new event wins
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_reg <= `TWBC_EVT_RESET;
        end else if (apb_wr && paddr == `TWBC_OFF_ISR) begin
            evt_reg <= (evt_reg & ~{pwdata[5:1], 1'b0}) | ev_vec;
        end else begin
            evt_reg <= evt_reg | ev_vec;
        end
    end

    // Read data captured in the setup cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h00000000;
        end else if (apb_rdst) begin
            case (paddr)
                `TWBC_OFF_CTRL:   prdata_reg <= {29'h0, ctrl_reg};
                `TWBC_OFF_CTRL2:  prdata_reg <= {19'h0, cr2_reg};
                `TWBC_OFF_TXDATA: prdata_reg <= {24'h0, txd_reg};
                `TWBC_OFF_RXDATA: prdata_reg <= {24'h0, rxd_reg};
                `TWBC_OFF_ISR:    prdata_reg <= {26'h0, evt_reg[5:1], bus_busy};
                `TWBC_OFF_MASK:   prdata_reg <= {26'h0, mask_reg};
                `TWBC_OFF_OWNADR: prdata_reg <= {25'h0, own_reg};
                default:          prdata_reg <= 32'h00000000;
            endcase
        end
    end

    // Interrupt and wakeup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg  <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            irq_reg  <= |(evt_reg & mask_reg);
            wake_reg <= stop_mode && pe && wake_en &&
                        (wake_reg || s_state_reg != S_IDLE);
        end
    end

    // Master engine; disabling aborts it and releases the lines
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m_state_reg  <= M_IDLE;
            tmr_reg      <= 16'h0000;
            bit_reg      <= 4'h0;
            shf_reg      <= 8'h00;
            phase_reg    <= P_HDR;
            m_scl_oe_reg <= 1'b0;
            m_sda_oe_reg <= 1'b0;
            rxd_reg      <= `TWBC_BYTE_RESET;
        end else if (!pe) begin
            m_state_reg  <= M_IDLE;
            m_scl_oe_reg <= 1'b0;
            m_sda_oe_reg <= 1'b0;
        end else begin
            case (m_state_reg)
                M_IDLE: begin
                    if (start_rq && !bus_busy && s_state_reg == S_IDLE) begin
                        m_sda_oe_reg <= 1'b1;
                        tmr_reg      <= HALF;
                        bit_reg      <= 4'h0;
                        phase_reg    <= P_HDR;
                        m_state_reg  <= M_STA;
                        if (addr10) begin
                            shf_reg <= {`TWBC_HDR10, cr2_reg[9:8], rd_dir};
                        end else begin
                            shf_reg <= {cr2_reg[6:0], rd_dir};
                        end
                    end
                end
                M_STA: begin
                    if (tmr_reg == 16'h0000) begin
                        m_scl_oe_reg <= 1'b1;
                        tmr_reg      <= HALF;
                        m_state_reg  <= M_BLO;
                    end else begin
                        tmr_reg <= tmr_reg - 16'h0001;
                    end
                end
                M_BLO: begin
                    // Data changes only while SCL is low
                    m_sda_oe_reg <= (bit_reg != 4'h8) && !shf_reg[7] &&
                                    !(phase_reg == P_DATA && rd_dir);
                    if (tmr_reg == 16'h0000) begin
                        m_scl_oe_reg <= 1'b0;
                        tmr_reg      <= HALF;
                        m_state_reg  <= M_BHI;
                    end else begin
                        tmr_reg <= tmr_reg - 16'h0001;
                    end
                end
                M_BHI: begin
                    // A low SCL from another party stretches the high phase
                    if (!scl_s) begin
                        tmr_reg <= HALF;
                    end else if (tmr_reg != 16'h0000) begin
                        tmr_reg <= tmr_reg - 16'h0001;
                    end else begin
                        m_scl_oe_reg <= 1'b1;
                        tmr_reg      <= HALF;
                        m_state_reg  <= M_BLO;
                        if (bit_reg != 4'h8) begin
                            shf_reg <= {shf_reg[6:0], sda_s};
                            bit_reg <= bit_reg + 4'h1;
                        end else begin
                            bit_reg <= 4'h0;
                            if (ev_nack) begin
                                m_state_reg <= M_SPO1;
                            end else if (phase_reg == P_HDR && addr10) begin
                                phase_reg <= P_LOW;
                                shf_reg   <= cr2_reg[7:0];
                            end else if (phase_reg != P_DATA) begin
                                phase_reg <= P_DATA;
                                shf_reg   <= rd_dir ? 8'hFF : txd_reg;
                            end else begin
                                if (rd_dir) begin
                                    rxd_reg <= shf_reg;
                                end
                                m_state_reg <= M_SPO1;
                            end
                        end
                    end
                end
                M_SPO1: begin
                    m_sda_oe_reg <= 1'b1;
                    if (tmr_reg == 16'h0000) begin
                        m_scl_oe_reg <= 1'b0;
                        tmr_reg      <= HALF;
                        m_state_reg  <= M_SPO2;
                    end else begin
                        tmr_reg <= tmr_reg - 16'h0001;
                    end
                end
                M_SPO2: begin
                    if (!scl_s) begin
                        tmr_reg <= HALF;
                    end else if (tmr_reg != 16'h0000) begin
                        tmr_reg <= tmr_reg - 16'h0001;
                    end else begin
                        m_sda_oe_reg <= 1'b0;
                        tmr_reg      <= HALF;
                        m_state_reg  <= M_SPO3;
                    end
                end
                M_SPO3: begin
                    // Bus free time before the next START
                    if (tmr_reg == 16'h0000) begin
                        m_state_reg <= M_IDLE;
                    end else begin
                        tmr_reg <= tmr_reg - 16'h0001;
                    end
                end
                default: begin
                    m_state_reg <= M_IDLE;
                end
            endcase
        end
    end

    // Slave address matcher with clock stretching
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_state_reg  <= S_IDLE;
            s_cnt_reg    <= 4'h0;
            s_shf_reg    <= 8'h00;
            s_scl_oe_reg <= 1'b0;
            s_sda_oe_reg <= 1'b0;
        end else if (!pe || stop_det) begin
            s_state_reg  <= S_IDLE;
            s_scl_oe_reg <= 1'b0;
            s_sda_oe_reg <= 1'b0;
        end else if (start_det && m_state_reg == M_IDLE) begin
            s_state_reg  <= S_ADDR;
            s_cnt_reg    <= 4'h0;
            s_scl_oe_reg <= 1'b0;
            s_sda_oe_reg <= 1'b0;
        end else begin
            case (s_state_reg)
                S_ADDR: begin
                    if (scl_rise && s_cnt_reg != 4'h8) begin
                        s_shf_reg <= {s_shf_reg[6:0], sda_s};
                        s_cnt_reg <= s_cnt_reg + 4'h1;
                    end else if (scl_fall && s_cnt_reg == 4'h8) begin
                        if (s_shf_reg[7:1] == own_reg) begin
                            s_sda_oe_reg <= 1'b1;
                            s_state_reg  <= S_ACK;
                        end else begin
                            s_state_reg <= S_IDLE;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_fall) begin
                        s_sda_oe_reg <= 1'b0;
                        if (!str_dis) begin
                            s_scl_oe_reg <= 1'b1;
                            s_state_reg  <= S_HOLD;
                        end else begin
                            s_state_reg <= S_IDLE;
                        end
                    end
                end
                S_HOLD: begin
                    // Release once software clears the address flag
                    if (!evt_reg[`TWBC_ISR_ADDR]) begin
                        s_scl_oe_reg <= 1'b0;
                        s_state_reg  <= S_IDLE;
                    end
                end
                default: begin
                    s_state_reg <= S_IDLE;
                end
            endcase
        end
    end

    assign prdata     = prdata_reg;
    assign pready     = 1'b1;
    assign pslverr    = psel && penable && !mapped(paddr);
    assign scl_out    = 1'b0;
    assign sda_out    = 1'b0;
    assign scl_oe     = m_scl_oe_reg | s_scl_oe_reg;
    assign sda_oe     = m_sda_oe_reg | s_sda_oe_reg;
    assign wakeup_req = wake_reg;
    assign irq        = irq_reg;

endmodule // twbc_top

`default_nettype wire

// [verif/twbc_chk.sv]
// Assertion checker for the two-wire bus controller top level.
// Assumes it is bound to twbc_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module twbc_chk (
    input wire logic        pclk,       // Clock
    input wire logic        presetn,    // Reset
    input wire logic [7:0]  paddr,      // Address
    input wire logic        psel,       // Select
    input wire logic        penable,    // Enable
    input wire logic        pwrite,     // Direction
    input wire logic [31:0] pwdata,     // Write data
    input wire logic [31:0] prdata,     // Read data
    input wire logic        pready,     // Ready
    input wire logic        pslverr,    // Error
    input wire logic        scl_in,     // SCL level
    input wire logic        scl_out,    // SCL value
    input wire logic        scl_oe,     // SCL pull
    input wire logic        sda_in,     // SDA level
    input wire logic        sda_out,    // SDA value
    input wire logic        sda_oe,     // SDA pull
    input wire logic        stop_mode,  // Stop mode
    input wire logic        wakeup_req, // Wakeup
    input wire logic        irq         // Interrupt
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_start_idle_bus: assert property ($rose(sda_oe) && scl_in && !scl_oe |-> $past(sda_in))
        else $error("START issued on a busy bus");
    a_wake_needs_stop: assert property (!$past(stop_mode) && !$past(stop_mode, 2) |-> !wakeup_req)
        else $error("wakeup outside Stop mode");
    a_irq_mask_off: assert property (psel && penable && pwrite && paddr == 8'h14
        && pwdata[5:0] == 6'h00 |=> ##1 !irq)
        else $error("irq high with all sources masked");
    a_disable_releases: assert property (psel && penable && pwrite && paddr == 8'h00
        && !pwdata[0] |-> ##[1:3] (!sda_oe && !scl_oe))
        else $error("lines still pulled after disable");
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    a_err_zero_data: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    a_pins_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("open drain value not low");
    cover property ($rose(sda_oe) && scl_in);
    cover property ($rose(irq));
    cover property (pslverr);
endmodule // twbc_chk
bind twbc_top twbc_chk u_chk (.*);
`default_nettype wire

// [verif/twbc_bus_partner.sv]
// Far side of the two-wire bus: an acknowledging slave and a busy injector.
// Assumes open-drain lines resolved with pull-ups by the bench.
`timescale 1ns/1ns
`default_nettype none
module twbc_bus_partner (
    input  wire logic       scl,      // Resolved SCL
    input  wire logic       sda,      // Resolved SDA
    input  wire logic       ack_en,   // Acknowledge bytes
    input  wire logic       hold_sda, // Other master holds SDA low
    output var  logic       sda_pull, // Pulls SDA low
    output var  logic [7:0] byte0,    // First byte after START
    output var  logic [7:0] byte1     // Second byte
);
    int         bits = 0;
    logic [7:0] sh = 8'h00;
    logic       ack = 1'b0;
    initial {byte0, byte1} = 16'h0000;
    always @* sda_pull = ack | hold_sda;
    always @(negedge sda) if (scl) begin
        bits = 0;
        ack = 1'b0;
    end
    always @(posedge scl) begin
        if (bits % 9 < 8) sh = {sh[6:0], sda};
        bits = bits + 1;
        if (bits == 8) byte0 = sh;
        if (bits == 17) byte1 = sh;
    end
    always @(negedge scl) ack = ack_en && (bits % 9 == 8);
endmodule // twbc_bus_partner
`default_nettype wire

// [verif/twbc_tb.sv]
// Self-checking bench: register table, then master transfers on the bus.
// Assumes twbc_top, the partner model and the checker are compiled.
`timescale 1ns/1ns
`default_nettype none
`include "twbc_defines.vh"
module twbc_tb;
    typedef struct {logic w; logic [7:0] a; logic [31:0] d, e; logic s;} twbc_row_t;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        stop_mode = 1'b0, ack_en = 1'b1, hold_sda = 1'b0, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, scl_out, sda_out, scl_oe, sda_oe, wakeup_req, irq, sda_pull;
    wire  [7:0]  byte0, byte1;
    wire         scl = !scl_oe;
    wire         sda = !(sda_oe || sda_pull);
    int          num_errors = 0, samples_checked = 0, cycles = 0;
    twbc_row_t   rows [11] = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h04, 0, 0, 0}, '{0, 8'h10, 0, 0, 0},
        '{0, 8'h14, 0, 0, 0}, '{0, 8'h1C, 0, 0, 1}, '{1, 8'h1C, 32'hFFFF, 0, 1},
        '{1, 8'h18, 32'h2A, 0, 0}, '{0, 8'h18, 0, 32'h2A, 0}, '{1, 8'h14, 32'h3F, 0, 0},
        '{0, 8'h14, 0, 32'h3E, 0}, '{0, 8'h0C, 0, 0, 0}};
    twbc_top #(.HALF_CYC(4)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .stop_mode(stop_mode), .wakeup_req(wakeup_req),
        .irq(irq));
    twbc_bus_partner u_far (.scl(scl), .sda(sda), .ack_en(ack_en), .hold_sda(hold_sda),
        .sda_pull(sda_pull), .byte0(byte0), .byte1(byte1));
    initial forever #25 pclk = ~pclk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_bit(input int b);
        do apb(1'b0, `TWBC_OFF_ISR, 32'h0); while (rd[b] !== 1'b1);
    endtask
    task automatic wrap_up;
        $display("Samples checked %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) check(rd, rows[i].e, "register read");
            check({31'h0, err}, {31'h0, rows[i].s}, "slave error");
        end
        $display("Test register table done");
        apb(1'b1, `TWBC_OFF_CTRL, 32'h1);
        hold_sda <= 1'b1;
        stop_mode <= 1'b1;
        apb(1'b1, `TWBC_OFF_TXDATA, 32'hA5);
        apb(1'b1, `TWBC_OFF_CTRL2, 32'h10FF);
        apb(1'b0, `TWBC_OFF_ISR, 32'h0);
        check(rd & 32'h1, 32'h1, "busy flag");
        repeat (40) @(posedge pclk);
        check({31'h0, scl_oe}, 32'h0, "START while busy");
        check({31'h0, wakeup_req}, 32'h0, "no wakeup");
        hold_sda <= 1'b0;
        stop_mode <= 1'b0;
        wait_bit(2);
        apb(1'b1, `TWBC_OFF_ISR, 32'h4);
        wait_bit(5);
        wait_bit(2);
        check({24'h0, byte0, byte1}, 32'hFEA5, "7-bit transfer");
        check({31'h0, irq}, 32'h1, "irq on done");
        apb(1'b0, `TWBC_OFF_CTRL2, 32'h0);
        check(rd & 32'h1000, 32'h0, "start cleared");
        apb(1'b1, `TWBC_OFF_ISR, 32'h3E);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0, "irq after clear");
        $display("Test busy bus and write done");
        ack_en <= 1'b0;
        apb(1'b1, `TWBC_OFF_MASK, 32'h0);
        apb(1'b1, `TWBC_OFF_CTRL2, 32'h1EAB);
        wait_bit(2);
        check(rd & 32'h6, 32'h6, "nack and stop flags");
        check({24'h0, byte0}, 32'hF5, "10-bit header");
        check({31'h0, irq}, 32'h0, "masked irq");
        apb(1'b0, `TWBC_OFF_CTRL2, 32'h0);
        check(rd & 32'h1000, 32'h0, "start cleared on nack");
        apb(1'b1, `TWBC_OFF_MASK, 32'h3E);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1, "unmasked irq");
        apb(1'b1, `TWBC_OFF_CTRL, 32'h0);
        repeat (3) @(posedge pclk);
        apb(1'b1, `TWBC_OFF_CTRL, 32'h1);
        apb(1'b1, `TWBC_OFF_ISR, 32'h3E);
        $display("Test 10-bit nack done");
        ack_en <= 1'b1;
        apb(1'b1, `TWBC_OFF_CTRL2, 32'h1AAB);
        wait_bit(2);
        check({24'h0, byte0, byte1}, 32'hF4AB, "10-bit bytes");
        $display("Test 10-bit write done");
        wrap_up();
    end
endmodule // twbc_tb
`default_nettype wire
